/* File: cra_pkg.sv */
/*
 * cra_pkg: shared types and constants of the receive acceptance filter.
 * Assumes a single 250 MHz controller clock; nothing here is clocked.
 */
package cra_pkg;

    // filter word and config widths
    localparam int CRA_FILT_W = 32;
    localparam int CRA_CAP_W = 8;

    // acceptance filter modes
    typedef enum logic [1:0] {
        cra_single_std = 2'b00,
        cra_single_ext = 2'b01,
        cra_dual_std = 2'b10,
        cra_dual_ext = 2'b11
    } cra_mode_type;

    // one decoded frame from the bit engine
    typedef struct packed {
        logic ext;           // 29-bit identifier format
        logic rtr;           // remote frame
        logic [3:0] dlc;     // data length code
        logic [28:0] id;     // identifier, standard id in [10:0]
        logic [63:0] data;   // byte 0 in [63:56]
    } cra_frame_type;

    // one read queue entry
    typedef struct packed {
        logic echo;          // own transmission echoed back
        cra_frame_type frame;
    } cra_entry_type;

    // configuration as held after a write
    typedef struct packed {
        logic echo_en;
        cra_mode_type mode;
        logic [CRA_FILT_W-1:0] comp;
        logic [CRA_FILT_W-1:0] mask;
        logic [CRA_CAP_W-1:0] cap;
        logic [CRA_CAP_W-1:0] thr;
        logic thr_set;       // threshold written explicitly
    } cra_cfg_type;

    // reset values
    localparam logic [CRA_FILT_W-1:0] CRA_COMP_RESET = 32'h0000_0000;
    localparam logic [CRA_FILT_W-1:0] CRA_MASK_RESET = 32'hFFFF_FFFF;
    localparam logic [CRA_CAP_W-1:0] CRA_CAP_RESET = 8'h10;
    localparam int CRA_HALF_SHIFT = 1;

    // filter regions of the compare word
    localparam logic [CRA_FILT_W-1:0] CRA_ALL_BITS = 32'hFFFF_FFFF;
    localparam logic [CRA_FILT_W-1:0] CRA_DS_F1_BITS = 32'hFFFF_000F;
    localparam logic [CRA_FILT_W-1:0] CRA_DS_F2_BITS = 32'h0000_FFF0;
    localparam logic [CRA_FILT_W-1:0] CRA_DE_F1_BITS = 32'hFFFF_0000;
    localparam logic [CRA_FILT_W-1:0] CRA_DE_F2_BITS = 32'h0000_FFFF;
    localparam logic [3:0] CRA_SS_RSV = 4'h0;
    localparam logic [1:0] CRA_SE_RSV = 2'h0;

endpackage : cra_pkg

/* File: cra_rx_filter.sv */
/*
 * cra_rx_filter: acceptance filtering, transmit echo and read queue.
 * Also holds cra_fifo, the queue storage.
 * Assumes the bit engine on the same clock hands over decoded frames
 * as one-cycle strobes and that host logic drains the queue.
 */
`timescale 1ns/100ps

// queue storage: registered flags, array memory
module cra_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    // fill level
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

    // whole control state in one word
    typedef struct packed {
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] count;
        logic full;
        logic avail;         // at least one entry; registered valid
    } cra_fifo_st_type;

    cra_fifo_st_type st;
    cra_fifo_st_type next_st;
    logic [WIDTH-1:0] mem [DEPTH];  // entry storage
    logic push;
    logic pop;

    // handshakes only from registered flags
    assign push = in_valid_i & ~st.full;
    assign pop = out_ready_i & st.avail;
    assign in_ready_o = ~st.full;
    // valid straight from its own flop, no inverter on the way out
    assign out_valid_o = st.avail;
    assign out_data_o = mem[st.rd];
    assign count_o = st.count;

    // pointer and level update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wr = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        // push and pop together leave the level alone
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
        next_st.full = (next_st.count == FULL_CNT);
        next_st.avail = (next_st.count != '0);
    end

    // state register; memory needs no reset
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st <= '0;  // empty: nothing valid, pointers home
        end else begin
            st <= next_st;
        end
        if (push) begin
            mem[st.wr] <= in_data_i;
        end
    end

endmodule : cra_fifo

// Overview of operation
// [RQ1] batch flag once unread count reaches threshold
// [RQ2] unread frames bounded by configurable queue capacity
// [RQ3] echo acknowledged own frames when echo enabled
// [RQ4] never echo unacknowledged own transmissions
// [RQ5] echo off after reset; own frames dropped
// [RQ6] one filter verdict gates every receive consumer
// [RQ7] reset filter mode is single standard
// [RQ8] dual extended: accept if either filter matches
// [RQ9] dual extended filters use identifier top 16
// [RQ10] dual standard: two filters, either accepts
// [RQ11] dual standard: filter1 adds byte0, filter2 not
// [RQ12] single extended: 29 id bits plus RTR
// [RQ13] single standard: id, RTR, data bytes 0,1
// [RQ14] configurer zeroes reserved compare and mask bits
// [RQ15] compare resets to zero, mapped per mode
// [RQ16] mask zero compares, mask one ignores
// [RQ17] mask resets all ones, accepting everything
// [RQ18] filter once per good frame, whole frames only
module cra_rx_filter
    import cra_pkg::*;
#(
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // configuration, taken on cfg_write_i
    input wire logic cfg_write_i,
    input wire logic tx_echo_enable_i,
    input wire cra_pkg::cra_mode_type accept_filter_mode_i,
    input wire logic [cra_pkg::CRA_FILT_W-1:0] accept_compare_value_i,
    input wire logic [cra_pkg::CRA_FILT_W-1:0] accept_mask_value_i,
    input wire logic [cra_pkg::CRA_CAP_W-1:0] rx_queue_capacity_i,
    // batch threshold, taken on thr_write_i
    input wire logic thr_write_i,
    input wire logic [cra_pkg::CRA_CAP_W-1:0] rx_batch_threshold_i,
    // frames from the bit engine
    input wire logic frame_valid_i,
    input wire logic frame_error_i,
    input wire logic frame_own_tx_i,
    input wire logic frame_acked_i,
    input wire cra_pkg::cra_frame_type frame_i,
    output logic frame_busy_o,
    // read queue towards host logic
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output cra_pkg::cra_entry_type rx_entry_o,
    // status
    output logic [$clog2(DEPTH):0] rx_count_o,
    output logic rx_batch_o,
    output logic frame_accept_o,
    output logic frame_drop_o
);
    import cra_pkg::*;

    localparam int CW = $clog2(DEPTH) + 1;
    localparam logic [CRA_CAP_W-1:0] DEPTH_CAP = CRA_CAP_W'(DEPTH);

    // whole control state in one word
    typedef struct packed {
        cra_cfg_type cfg;
        logic pend_valid;         // entry waiting for the queue
        cra_entry_type pend;
        logic batch;
        logic accept;
        logic drop;
    } cra_top_st_type;

    cra_top_st_type st;
    cra_top_st_type next_st;
    logic [CW-1:0] fifo_count;    // unread frames
    logic fifo_in_ready;
    logic fifo_out_valid;
    cra_entry_type fifo_out;
    logic [CRA_CAP_W-1:0] eff_cap;
    logic [CRA_CAP_W-1:0] eff_thr;
    logic [CRA_CAP_W-1:0] unread;
    logic below_cap;
    logic push_ok;
    logic take;
    logic pass;

    // acceptance test of one frame against the current filter
    function automatic logic cra_match(
        input cra_mode_type mode,
        input cra_frame_type f,
        input logic [CRA_FILT_W-1:0] comp,
        input logic [CRA_FILT_W-1:0] mask
    );
        logic [CRA_FILT_W-1:0] img;
        logic [CRA_FILT_W-1:0] eq;
        logic [CRA_FILT_W-1:0] reg1;
        logic [CRA_FILT_W-1:0] reg2;
        logic [7:0] d0;
        logic [7:0] d1;
        logic lay_ext;
        logic f1;
        logic f2;
        d0 = f.data[63:56];
        d1 = f.data[55:48];
        lay_ext = (mode == cra_single_ext) || (mode == cra_dual_ext);
        reg1 = CRA_ALL_BITS;
        reg2 = '0;
        // map frame bits onto the compare word [RQ15]
        case (mode)
            cra_single_std: begin
                img = {f.id[10:0], f.rtr, CRA_SS_RSV, d0, d1};  // [RQ13] [RQ14]
            end
            cra_single_ext: begin
                img = {f.id, f.rtr, CRA_SE_RSV};  // [RQ12] [RQ14]
            end
            cra_dual_std: begin
                // filter1 splits byte 0 round filter2 [RQ11]
                img = {f.id[10:0], f.rtr, d0[7:4], f.id[10:0], f.rtr, d0[3:0]};
                reg1 = CRA_DS_F1_BITS;
                reg2 = CRA_DS_F2_BITS;
            end
            default: begin
                img = {f.id[28:13], f.id[28:13]};  // [RQ9]
                reg1 = CRA_DE_F1_BITS;
                reg2 = CRA_DE_F2_BITS;
            end
        endcase
        // a set mask bit forgives a mismatch [RQ16]
        eq = ~(img ^ comp) | mask;
        f1 = &(eq | ~reg1);
        f2 = (reg2 != '0) && (&(eq | ~reg2));
        // other format is not filtered in this mode
        if (f.ext != lay_ext) begin
            cra_match = 1'b1;
        end else begin
            cra_match = f1 | f2;  // [RQ8] [RQ10]
        end
    endfunction : cra_match

    // capacity clamps to the storage actually built [RQ2]
    always_comb begin
        if (st.cfg.cap > DEPTH_CAP) begin
            eff_cap = DEPTH_CAP;
        end else begin
            eff_cap = st.cfg.cap;
        end
    end

    // threshold follows half capacity until written [RQ1]
    assign eff_thr = st.cfg.thr_set ? st.cfg.thr : (st.cfg.cap >> CRA_HALF_SHIFT);
    assign unread = CRA_CAP_W'(fifo_count);
    assign below_cap = (unread < eff_cap);  // [RQ2]
    assign push_ok = st.pend_valid & fifo_in_ready & below_cap;

    // only whole error-free frames are looked at [RQ18]
    // own frames need both echo and an acknowledge [RQ3] [RQ4] [RQ5]
    assign take = frame_valid_i & ~frame_error_i
        & (~frame_own_tx_i | (frame_acked_i & st.cfg.echo_en));
    // one verdict for queue and every consumer behind it [RQ6]
    assign pass = take & cra_match(st.cfg.mode, frame_i, st.cfg.comp, st.cfg.mask);

    // next state
    always_comb begin
        next_st = st;
        next_st.accept = 1'b0;
        next_st.drop = 1'b0;
        // configuration load; a frame this cycle sees the old set
        if (cfg_write_i) begin
            next_st.cfg.echo_en = tx_echo_enable_i;
            next_st.cfg.mode = accept_filter_mode_i;
            next_st.cfg.comp = accept_compare_value_i;
            next_st.cfg.mask = accept_mask_value_i;
            next_st.cfg.cap = rx_queue_capacity_i;
        end
        if (thr_write_i) begin
            next_st.cfg.thr = rx_batch_threshold_i;
            next_st.cfg.thr_set = 1'b1;
        end
        // pending entry leaves for the queue
        if (push_ok) begin
            next_st.pend_valid = 1'b0;
        end
        // enqueue only after the verdict is known [RQ18]
        if (pass) begin
            if (!st.pend_valid || push_ok) begin
                next_st.pend_valid = 1'b1;
                next_st.pend.echo = frame_own_tx_i;  // [RQ3]
                next_st.pend.frame = frame_i;
                next_st.accept = 1'b1;
            end else begin
                // stage still blocked: frame is lost, not split
                next_st.drop = 1'b1;
            end
        end
        next_st.batch = (unread >= eff_thr);  // [RQ1]
    end

    // state register with configuration defaults
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st <= '0;  // echo off, single standard [RQ5] [RQ7]
            st.cfg.comp <= CRA_COMP_RESET;  // [RQ15]
            st.cfg.mask <= CRA_MASK_RESET;  // [RQ17]
            st.cfg.cap <= CRA_CAP_RESET;
        end else begin
            st <= next_st;
        end
    end

    // read queue; a stalled host fills it and blocks the stage
    cra_fifo #(
        .WIDTH($bits(cra_entry_type)),
        .DEPTH(DEPTH)
    ) u_queue (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(st.pend_valid & below_cap),
        .in_ready_o(fifo_in_ready),
        .in_data_i(st.pend),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(rx_ready_i),
        .out_data_o(fifo_out),
        .count_o(fifo_count)
    );

    // outputs
    assign rx_valid_o = fifo_out_valid;
    assign rx_entry_o = fifo_out;
    assign rx_count_o = fifo_count;
    assign rx_batch_o = st.batch;
    assign frame_busy_o = st.pend_valid;
    assign frame_accept_o = st.accept;
    assign frame_drop_o = st.drop;

endmodule : cra_rx_filter

/* File: cra_node_model.sv */
/* cra_node_model: far side of the filter, frames decoded from the bus.
   Assumes the filter samples on the rising edge of clock_i. */
`timescale 1ns/100ps
module cra_node_model
    import cra_pkg::*;
(
    // clock
    input wire logic clock_i,
    // decoded frame strobe
    output logic frame_valid_o,
    output logic frame_error_o,
    output logic frame_own_tx_o,
    output logic frame_acked_o,
    output cra_pkg::cra_frame_type frame_o
);
    // quiet bus at time zero
    initial begin
        frame_valid_o <= 1'b0;
        frame_error_o <= 1'b0;
        frame_own_tx_o <= 1'b0;
        frame_acked_o <= 1'b0;
        frame_o <= '0;
    end
    // one frame, complete at the next edge
    task automatic send(input cra_frame_type f, input logic e, o, a);
        @(posedge clock_i);
        frame_valid_o <= 1'b1;
        frame_error_o <= e;
        frame_own_tx_o <= o;
        frame_acked_o <= a;
        frame_o <= f;
    endtask : send
    // stale word inverted so nothing leans on a held value
    task automatic idle();
        @(posedge clock_i);
        frame_valid_o <= 1'b0;
        frame_acked_o <= ~frame_acked_o;
        frame_o <= ~frame_o;
    endtask : idle
endmodule : cra_node_model

/* File: cra_rx_filter_monitor.sv */
/* cra_rx_filter_monitor: port checks of the receive filter.
   Assumes a bind onto cra_rx_filter, one clock, sync low reset. */
`timescale 1ns/100ps
module cra_rx_filter_monitor #(
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // inputs watched
    input wire logic frame_valid_i,
    input wire logic frame_error_i,
    input wire logic frame_own_tx_i,
    input wire logic frame_acked_i,
    input wire logic rx_ready_i,
    // outputs watched
    input wire logic frame_busy_o,
    input wire logic rx_valid_o,
    input wire logic [$clog2(DEPTH):0] rx_count_o,
    input wire logic rx_batch_o,
    input wire logic frame_accept_o,
    input wire logic frame_drop_o
);
    // one domain only
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_accept_has_cause: assert property (
        frame_accept_o |-> $past(frame_valid_i && !frame_error_i))
        else $error("accept pulse without a good frame");
    a_error_no_pulse: assert property (
        frame_valid_i && frame_error_i |=> !frame_accept_o && !frame_drop_o)
        else $error("bad frame produced a pulse");
    a_unacked_no_echo: assert property (
        frame_valid_i && frame_own_tx_i && !frame_acked_i |=> !frame_accept_o && !frame_drop_o)
        else $error("unacknowledged own frame taken");
    a_accept_fills_stage: assert property (
        frame_accept_o |-> frame_busy_o)
        else $error("accepted frame not staged");
    a_pulses_exclusive: assert property (
        !(frame_accept_o && frame_drop_o))
        else $error("accept and drop together");
    a_count_bounded: assert property (
        rx_count_o <= DEPTH && rx_valid_o == (rx_count_o != 0))
        else $error("queue count out of range");
    a_pop_decrements: assert property (
        rx_valid_o && rx_ready_i && !frame_busy_o |=> rx_count_o == $past(rx_count_o) - 1)
        else $error("pop did not lower count");
    a_reset_empties: assert property (
        disable iff (1'b0) !rst_n_i |=> rx_count_o == 0 && !rx_valid_o && !frame_busy_o)
        else $error("reset left queue state");
    // main scenarios reached
    c_accept: cover property (frame_accept_o);
    c_drop: cover property (frame_drop_o);
    c_batch: cover property ($rose(rx_batch_o));
endmodule : cra_rx_filter_monitor

/* File: cra_rx_filter_tb.sv */
/* cra_rx_filter_tb: directed bench of filter modes, echo and queue.
   Assumes cra_pkg, cra_rx_filter and cra_node_model compiled first. */
`timescale 1ns/100ps
module cra_rx_filter_tb;
    import cra_pkg::*;
    // stimulus and observed signals
    logic clock_i, rst_n_i, cfg_write_i, echo, thr_write_i, rx_ready_i;
    cra_mode_type mode;
    logic [31:0] comp, mask;
    logic [7:0] cap, thr;
    logic fv, fe, fo, fa, busy, rvalid, batch, acc, drop;
    cra_frame_type fr;
    cra_entry_type ent;
    logic [4:0] cnt;
    int mismatches, n_compared, exp_n;
    logic [29:0] expq[$]; // echo flag and id per queued frame
    int n_acc = 0, n_drop = 0; // pulse tallies since start
    // pulses read at the edge after they are launched
    always @(posedge clock_i) begin
        if (rst_n_i) begin
            n_acc <= n_acc + int'(acc);
            n_drop <= n_drop + int'(drop);
        end
    end
    // 4 ns clock
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    cra_node_model u_node (.clock_i(clock_i), .frame_valid_o(fv), .frame_error_o(fe),
        .frame_own_tx_o(fo), .frame_acked_o(fa), .frame_o(fr));
    cra_rx_filter #(.DEPTH(16)) u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .cfg_write_i(cfg_write_i), .tx_echo_enable_i(echo), .accept_filter_mode_i(mode),
        .accept_compare_value_i(comp), .accept_mask_value_i(mask),
        .rx_queue_capacity_i(cap), .thr_write_i(thr_write_i), .rx_batch_threshold_i(thr),
        .frame_valid_i(fv), .frame_error_i(fe), .frame_own_tx_i(fo), .frame_acked_i(fa),
        .frame_i(fr), .frame_busy_o(busy), .rx_valid_o(rvalid), .rx_ready_i(rx_ready_i),
        .rx_entry_o(ent), .rx_count_o(cnt), .rx_batch_o(batch), .frame_accept_o(acc),
        .frame_drop_o(drop));
    // compare one value
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    // load configuration, live from the next cycle
    task automatic cfg(input logic e, input cra_mode_type m, input logic [31:0] c, k,
                       input logic [7:0] q);
        @(posedge clock_i);
        cfg_write_i <= 1'b1;
        echo <= e;
        mode <= m;
        comp <= c;
        mask <= k;
        cap <= q;
        @(posedge clock_i);
        cfg_write_i <= 1'b0;
    endtask : cfg
    // one frame, then the expected queue fill
    task automatic fx(input logic er, x, r, input logic [28:0] id, input logic [15:0] d,
                      input logic o, a, ok);
        u_node.send('{x, r, 4'h8, id, {d, 48'h0}}, er, o, a);
        u_node.idle();
        repeat (3) @(posedge clock_i);
        #1;
        if (ok) begin
            exp_n++;
            expq.push_back({o, id});
        end
        chk("rx_count", exp_n, cnt);
    endtask : fx
    // pop the head and compare it with the oldest expectation
    task automatic pop();
        logic [29:0] e;
        e = expq.pop_front();
        #1;
        chk("rx_entry", e, {ent.echo, ent.frame.id});
        @(posedge clock_i);
        rx_ready_i <= 1'b1;
        @(posedge clock_i);
        rx_ready_i <= 1'b0;
        exp_n--;
    endtask : pop
    // verdict, the only exit
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    // hang guard, far beyond the roughly 135 cycles needed
    initial begin
        repeat (20000) @(posedge clock_i);
        mismatches++;
        test_done();
    end
    // main sequence
    initial begin
        {cfg_write_i, echo, thr_write_i, rx_ready_i} <= 4'h0;
        {comp, mask, cap, thr} <= 80'h0;
        mode <= cra_single_std;
        rst_n_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        fx(0, 0, 0, 29'h123, 16'hA55A, 0, 0, 1);
        fx(0, 0, 0, 29'h124, 16'h0, 1, 1, 0);
        cfg(0, cra_single_std, {11'h123, 1'b0, 4'h0, 16'hA55A}, 0, 8'h10);
        fx(0, 0, 0, 29'h123, 16'hA55A, 0, 0, 1);
        fx(0, 0, 0, 29'h123, 16'hA55B, 0, 0, 0);
        cfg(0, cra_single_std, {11'h123, 1'b0, 4'h0, 16'hA55A}, 32'hFFFF, 8'h10);
        fx(0, 0, 0, 29'h123, 16'h0, 0, 0, 1);
        cfg(0, cra_single_ext, {29'h0ABCDEF1, 3'h0}, 0, 8'h10);
        fx(0, 1, 1, 29'h0ABCDEF1, 16'h0, 0, 0, 0);
        fx(0, 1, 0, 29'h0ABCDEF1, 16'h0, 0, 0, 1);
        cfg(0, cra_dual_std, {11'h100, 1'b0, 4'h3, 11'h200, 1'b0, 4'hC}, 0, 8'h10);
        fx(0, 0, 0, 29'h200, 16'h0, 0, 0, 1);
        fx(0, 0, 0, 29'h100, 16'h3D00, 0, 0, 0);
        fx(0, 0, 0, 29'h100, 16'h3C00, 0, 0, 1);
        cfg(0, cra_dual_ext, {16'h1234, 16'h0F0F}, 0, 8'h10);
        fx(0, 1, 0, {16'h0F0F, 13'h1ABC}, 16'h0, 0, 0, 1);
        fx(0, 1, 0, {16'h1111, 13'h0}, 16'h0, 0, 0, 0);
        cfg(1, cra_single_std, 0, 32'hFFFFFFFF, 8'h10);
        fx(0, 0, 0, 29'h55, 16'h0, 1, 1, 1);
        fx(0, 0, 0, 29'h56, 16'h0, 1, 0, 0);
        fx(1, 0, 0, 29'h57, 16'h0, 0, 0, 0);
        chk("rx_batch", 1, batch);
        repeat (8) pop();
        #1;
        chk("rx_count", 0, cnt);
        cfg(0, cra_single_std, 0, 32'hFFFFFFFF, 8'h4);
        repeat (6) u_node.send('{1'b0, 1'b0, 4'h8, 29'h9, 64'h0}, 0, 0, 0);
        u_node.idle();
        repeat (4) @(posedge clock_i);
        #1;
        chk("rx_count", 4, cnt);
        chk("frame_busy", 1, busy);
        chk("rx_valid", 1, rvalid);
        chk("accept_pulses", 13, n_acc);
        chk("drop_pulses", 1, n_drop);
        chk("rx_batch", 1, batch);
        @(posedge clock_i);
        thr_write_i <= 1'b1;
        thr <= 8'h5;
        @(posedge clock_i);
        thr_write_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        #1;
        chk("rx_batch", 0, batch);
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        exp_n = 0;
        fx(0, 0, 0, 29'h7, 16'h0, 1, 1, 0);
        test_done();
    end
endmodule : cra_rx_filter_tb

bind cra_rx_filter cra_rx_filter_monitor #(.DEPTH(DEPTH)) u_mon (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .frame_valid_i(frame_valid_i), .frame_error_i(frame_error_i),
    .frame_own_tx_i(frame_own_tx_i), .frame_acked_i(frame_acked_i),
    .rx_ready_i(rx_ready_i), .frame_busy_o(frame_busy_o), .rx_valid_o(rx_valid_o),
    .rx_count_o(rx_count_o), .rx_batch_o(rx_batch_o), .frame_accept_o(frame_accept_o),
    .frame_drop_o(frame_drop_o));
